//--- design/psram_mode_ctl.v
// host controller that programs the pseudo-static ram mode register
// and walks it in and out of its low-power standby states
// assumes software on a plain strobe port; pins go straight to the memory
//
// Function
// [R1] modes change only via the mode register
// [R2] partial refresh keeps 16, 32 or 48Mb
// [R3] sleep with partial refresh keeps region only
// [R4] sleep pin high restores full refresh
// [R5] region persists until register is reprogrammed
// [R6] low_power_select 1: partial refresh after 10us
// [R7] low_power_select 0: deep sleep after 10us
// [R8] deep sleep lasts while sleep pin low
// [R9] four temperature settings pick refresh rate
// [R10] reduced size active from sleep pin rise
// [R11] no access to deselected array portion
// [R12] full size needs reprogramming with full setting
// [R13] page_enable bit switches page mode
// [R14] deselect 5ns, write 10-500ns after sleep
// [R15] write cycle speed grade, pulse 40ns
// [R16] sleep low 10us, recover 200us; recovery skipped if wake is pending as 10us ends with array_lost still clear
// [R17] 64Mb region codes on address bits 2..0
// [R18] 32Mb partial refresh kind and region codes
// [R19] 32Mb reduced size uses bits 3,4 set
// [R20] setting captured at write strobe end
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "psram_mode_ctl_consts.vh"
module psram_mode_ctl #(
   parameter RECOVER_CYC = `CYC_UP(`T_SLEEP_RECOVER_US * 1000),
   parameter TIMER_W = 13
) (
   input wire ref_clk_i,
   input wire srst_i,
   input wire [7:0] addr_i,
   input wire [31:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rd_data_o,
   output reg [`MODE_W-1:0] psram_addr_o,
   output reg chip_en_n_o,
   output reg chip_en2_o,
   output reg write_n_o,
   output reg out_en_n_o,
   output reg upper_byte_select_n_o,
   output reg lower_byte_select_n_o,
   output reg sleep_select_n_o
);
   // ==========================================================
   // timing counts
   localparam DESEL_CYC = `CYC_UP(`T_DESEL_TO_SLEEP_NS);
   localparam ZZWE_MIN_CYC = `CYC_UP(`T_SLEEP_TO_WRITE_MIN_NS);
   localparam ZZWE_MAX_CYC = `CYC_DN(`T_SLEEP_TO_WRITE_MAX_NS);
   localparam WR_NS = (`T_SPEED_GRADE_NS > `T_WRITE_PULSE_NS) ?
      `T_SPEED_GRADE_NS : `T_WRITE_PULSE_NS;
   localparam WR_CYC = `CYC_UP(WR_NS);
   localparam SLEEP_MIN_CYC = `CYC_UP(`T_SLEEP_MIN_US * 1000);

   localparam [TIMER_W-1:0] DESEL_LOAD = DESEL_CYC[TIMER_W-1:0];
   localparam [TIMER_W-1:0] ZZWE_LOAD = ZZWE_MIN_CYC[TIMER_W-1:0];
   localparam [TIMER_W-1:0] WR_LOAD = WR_CYC[TIMER_W-1:0];
   localparam [TIMER_W-1:0] SLEEP_LOAD = SLEEP_MIN_CYC[TIMER_W-1:0];
   localparam [TIMER_W-1:0] RECOVER_LOAD = RECOVER_CYC[TIMER_W-1:0];

   // ==========================================================
   // states
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_DESEL = 3'h1;
   localparam [2:0] S_SLEEP_LOW = 3'h2;
   localparam [2:0] S_WRITE = 3'h3;
   localparam [2:0] S_WRITE_END = 3'h4;
   localparam [2:0] S_SLEEP = 3'h5;
   localparam [2:0] S_RECOVER = 3'h6;

   reg [2:0] state;
   reg [2:0] next_state;
   reg sleep_goal;
   reg [`MODE_W-1:0] mode_setting;
   reg [`MODE_W-1:0] mode_in_device;
   reg programmed;
   reg wake_pending;
   reg low_power_entered;
   reg array_lost;
   reg reduced_active;
   reg tmr_load;
   reg [TIMER_W-1:0] tmr_count;
   wire tmr_expired;

   wire cmd_wr = wr_i && (addr_i == `REG_CMD);
   wire mode_wr = wr_i && (addr_i == `REG_MODE);
   wire start_program = cmd_wr && wr_data_i[`CMD_PROGRAM] && (state == S_IDLE);
   wire start_sleep = cmd_wr && wr_data_i[`CMD_SLEEP] && (state == S_IDLE);
   wire wake_req = cmd_wr && wr_data_i[`CMD_WAKE] && (state == S_SLEEP);
   // reduced size on the 32Mb die: kind and low-power bits both set
   // read from the pins, which still hold the setting as the shadow is loaded
   wire setting_reduced = psram_addr_o[`MODE_KIND] && psram_addr_o[`MODE_LOW_POWER];

   interval_timer #(
      .W(TIMER_W)
   ) u_timer (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .load_i(tmr_load),
      .count_i(tmr_count),
      .expired_o(tmr_expired)
   );

   // ==========================================================
   // sequencer
   always @* begin
      next_state = state;
      tmr_load = 1'b0;
      tmr_count = {TIMER_W{1'b0}};
      case (state)
         S_IDLE: begin
            if (start_program || start_sleep) begin
               next_state = S_DESEL; // R14
               tmr_load = 1'b1;
               tmr_count = DESEL_LOAD;
            end
         end
         S_DESEL: begin
            if (tmr_expired) begin
               next_state = sleep_goal ? S_SLEEP : S_SLEEP_LOW;
               tmr_load = 1'b1;
               tmr_count = sleep_goal ? SLEEP_LOAD : ZZWE_LOAD;
            end
         end
         S_SLEEP_LOW: begin
            // strobe drops on the second edge after the sleep pin falls, well inside the upper bound
            if (tmr_expired) begin
               next_state = S_WRITE; // R14
               tmr_load = 1'b1;
               tmr_count = WR_LOAD;
            end
         end
         S_WRITE: begin
            if (tmr_expired) begin
               next_state = S_WRITE_END; // R15
            end
         end
         S_WRITE_END: begin
            next_state = S_IDLE;
         end
         S_SLEEP: begin
            // the sleep pin stays low at least the minimum pulse
            if (tmr_expired && (wake_pending || wake_req)) begin
               next_state = array_lost ? S_RECOVER : S_IDLE; // R16
               tmr_load = array_lost;
               tmr_count = RECOVER_LOAD;
            end
         end
         S_RECOVER: begin
            if (tmr_expired) begin
               next_state = S_IDLE; // R16
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state, mode shadow and pins
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         state <= S_IDLE;
         sleep_goal <= 1'b0;
         mode_setting <= `MODE_RESET;
         mode_in_device <= `MODE_RESET;
         programmed <= 1'b0;
         wake_pending <= 1'b0;
         low_power_entered <= 1'b0;
         array_lost <= 1'b0;
         reduced_active <= 1'b0;
         psram_addr_o <= {`MODE_W{1'b0}};
         chip_en_n_o <= 1'b1;
         chip_en2_o <= 1'b0;
         write_n_o <= 1'b1;
         out_en_n_o <= 1'b1;
         upper_byte_select_n_o <= 1'b1;
         lower_byte_select_n_o <= 1'b1;
         sleep_select_n_o <= 1'b1;
         rd_data_o <= 32'h0;
      end else begin
         state <= next_state;
         if (mode_wr) begin
            // region, kind, low-power, temperature and page fields
            mode_setting <= wr_data_i[`MODE_W-1:0]; // R1 R2 R9 R13 R17 R18 R19
         end
         if (start_program || start_sleep) begin
            sleep_goal <= start_sleep;
         end
         chip_en_n_o <= 1'b1;
         chip_en2_o <= 1'b0;
         write_n_o <= 1'b1;
         // byte selects and output enable stay idle: ignored by the capture
         case (next_state)
            S_SLEEP_LOW: begin
               sleep_select_n_o <= 1'b0;
            end
            S_WRITE: begin
               sleep_select_n_o <= 1'b0;
               chip_en_n_o <= 1'b0;
               chip_en2_o <= 1'b1;
               write_n_o <= 1'b0;
               psram_addr_o <= mode_setting;
            end
            S_WRITE_END: begin
               // sleep stays low one cycle past the strobe rise so the capture lands
               sleep_select_n_o <= 1'b0;
            end
            S_SLEEP: begin
               sleep_select_n_o <= 1'b0; // R8
            end
            default: begin
               sleep_select_n_o <= 1'b1;
            end
         endcase
         // address holds past the strobe rise so the device latches it
         if (state == S_WRITE_END) begin
            mode_in_device <= psram_addr_o; // R20 R5
            programmed <= 1'b1;
            array_lost <= 1'b0;
         end
         if (state == S_SLEEP && tmr_expired && !low_power_entered) begin
            low_power_entered <= 1'b1;
            // partial refresh keeps data, deep sleep loses it
            array_lost <= !mode_in_device[`MODE_LOW_POWER]; // R6 R7 R3
         end
         if (next_state != S_SLEEP) begin
            low_power_entered <= 1'b0; // R4
         end
         if (wake_req) begin
            wake_pending <= 1'b1;
         end else if (next_state != S_SLEEP) begin
            wake_pending <= 1'b0;
         end
         // reduced size only counts once the sleep pin has risen again
         if (state == S_WRITE_END) begin
            reduced_active <= setting_reduced; // R10 R12
         end else if (state == S_WRITE) begin
            reduced_active <= 1'b0;
         end
         rd_data_o <= 32'h0;
         if (rd_i) begin
            case (addr_i)
               `REG_MODE: begin
                  rd_data_o <= {{(32-`MODE_W){1'b0}}, mode_setting};
               end
               `REG_STATUS: begin
                  rd_data_o[`ST_BUSY] <= (state != S_IDLE);
                  rd_data_o[`ST_IN_SLEEP] <= (state == S_SLEEP);
                  rd_data_o[`ST_LOW_POWER] <= low_power_entered;
                  rd_data_o[`ST_ARRAY_LOST] <= array_lost;
                  // software reads this to keep away from the dropped part
                  rd_data_o[`ST_REDUCED] <= reduced_active; // R11
                  rd_data_o[`ST_PAGE] <= mode_in_device[`MODE_PAGE]; // R13
                  rd_data_o[`ST_PROGRAMMED] <= programmed;
               end
               default: begin
                  rd_data_o <= 32'h0;
               end
            endcase
         end
      end
   end
endmodule

//--- design/psram_mode_ctl_consts.vh
// constants for the pseudo-static ram mode register controller
// assumes a 25 MHz controller clock; included by bare name
`ifndef PSRAM_MODE_CTL_CONSTS_VH
`define PSRAM_MODE_CTL_CONSTS_VH

`define CLK_PERIOD_NS 40

// pin timing figures as printed
`define T_DESEL_TO_SLEEP_NS 5
`define T_SLEEP_TO_WRITE_MIN_NS 10
`define T_SLEEP_TO_WRITE_MAX_NS 500
`define T_SPEED_GRADE_NS 85
`define T_WRITE_PULSE_NS 40
`define T_SLEEP_MIN_US 10
`define T_SLEEP_RECOVER_US 200

// least times round up, longest times round down
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DN(ns) ((ns) / `CLK_PERIOD_NS)

// software register byte addresses
`define REG_CMD 8'h00
`define REG_MODE 8'h04
`define REG_STATUS 8'h08

// command register bits
`define CMD_PROGRAM 0
`define CMD_SLEEP 1
`define CMD_WAKE 2

// mode setting fields as driven on the address pins
`define MODE_W 22
`define MODE_REGION_HI 2
`define MODE_REGION_LO 0
`define MODE_KIND 3
`define MODE_LOW_POWER 4
`define MODE_TEMP_HI 6
`define MODE_TEMP_LO 5
`define MODE_PAGE 7
`define MODE_RESET 22'h000010

// status register bits
`define ST_BUSY 0
`define ST_IN_SLEEP 1
`define ST_LOW_POWER 2
`define ST_ARRAY_LOST 3
`define ST_REDUCED 4
`define ST_PAGE 5
`define ST_PROGRAMMED 6

`endif

//--- design/interval_timer.v
// down-counting interval timer for the mode controller
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module interval_timer #(
   parameter W = 13
) (
   input wire ref_clk_i,
   input wire srst_i,
   input wire load_i,
   input wire [W-1:0] count_i,
   output wire expired_o
);
   reg [W-1:0] remaining;

   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         remaining <= {W{1'b0}};
      end else if (load_i) begin
         remaining <= count_i;
      end else if (remaining != {W{1'b0}}) begin
         remaining <= remaining - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign expired_o = (remaining == {W{1'b0}});
endmodule

//--- dv/psram_dev_model.sv
// behavioural pseudo-static ram: mode register and standby states only
// assumes controller pins; no clock, times are real time
`timescale 1ns/100ps
module psram_dev_model #(
   parameter [21:0] MODE_INIT = 22'h000010,
   parameter real T_ENTER_NS = 10000.0
) (
   input wire [21:0] psram_addr_i,
   input wire chip_en_n_i,
   input wire chip_en2_i,
   input wire write_n_i,
   input wire sleep_n_i,
   output logic [21:0] mode_o = MODE_INIT,
   output logic partial_o = 1'b0,
   output logic deep_o = 1'b0,
   output logic reduced_o = 1'b0
);
   // ==========
   // register capture
   logic [21:0] pend;
   realtime t_fall = 0.0;
   // byte selects and output enable play no part in the capture
   always @* if (!write_n_i && !chip_en_n_i && chip_en2_i && !sleep_n_i) pend = psram_addr_i;
   always @(posedge write_n_i) if (!sleep_n_i) mode_o = pend;
   // ==========
   // standby
   always @(negedge sleep_n_i) begin
      t_fall = $realtime;
      fork
         begin
            #(T_ENTER_NS);
            // a later fall restarts the count
            if (!sleep_n_i && $realtime - t_fall >= T_ENTER_NS) begin
               partial_o = mode_o[4];
               deep_o = !mode_o[4];
            end
         end
      join_none
   end
   always @(posedge sleep_n_i) begin
      partial_o = 1'b0;
      deep_o = 1'b0;
      reduced_o = mode_o[4] & mode_o[3];
   end
endmodule

//--- dv/psram_mode_ctl_chk.sv
// pin-side assertions for the mode register controller
// assumes binding into psram_mode_ctl; one clock, synchronous reset
`timescale 1ns/100ps
module psram_mode_ctl_chk #(
   parameter RECOVER_CYC = 5000
) (
   input wire ref_clk_i,
   input wire srst_i,
   input wire [21:0] psram_addr_o,
   input wire chip_en_n_o,
   input wire chip_en2_o,
   input wire write_n_o,
   input wire sleep_select_n_o
);
   // ==========
   // sleep-low bookkeeping
   logic [8:0] lo_cnt;
   logic wrote;
   always @(posedge ref_clk_i) begin
      if (srst_i || sleep_select_n_o) begin
         lo_cnt <= 9'h0;
         wrote <= 1'b0;
      end else begin
         if (lo_cnt != 9'h1ff) lo_cnt <= lo_cnt + 9'h1;
         if (!write_n_o) wrote <= 1'b1;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence wr_low;
      (!write_n_o && !chip_en_n_o && chip_en2_o)[*3];
   endsequence
   sequence wr_release;
      write_n_o && chip_en_n_o && !sleep_select_n_o ##1 sleep_select_n_o;
   endsequence
   desel_sleep_a: assert property ($fell(sleep_select_n_o) |-> $past(chip_en_n_o))
      else $error("chip selected as sleep pin fell");
   sleep_to_wr_a: assert property ($fell(write_n_o) |-> lo_cnt inside {[1:12]})
      else $error("write strobe outside sleep window");
   wr_pulse_a: assert property ($fell(write_n_o) |-> wr_low)
      else $error("register write too short");
   addr_hold_a: assert property (!write_n_o ##1 !write_n_o |-> $stable(psram_addr_o))
      else $error("address moved during write");
   wr_end_a: assert property ($rose(write_n_o) |-> wr_release)
      else $error("write did not end inside sleep");
   sleep_len_a: assert property ($rose(sleep_select_n_o) |-> wrote || lo_cnt >= 9'd250)
      else $error("sleep pin low too short");
   awake_idle_a: assert property (sleep_select_n_o |-> write_n_o)
      else $error("write while awake");
   ce_pair_a: assert property (chip_en_n_o != chip_en2_o)
      else $error("chip enables disagree");
endmodule
bind psram_mode_ctl psram_mode_ctl_chk #(.RECOVER_CYC(RECOVER_CYC)) chk_inst (
   .ref_clk_i(ref_clk_i),
   .srst_i(srst_i),
   .psram_addr_o(psram_addr_o),
   .chip_en_n_o(chip_en_n_o),
   .chip_en2_o(chip_en2_o),
   .write_n_o(write_n_o),
   .sleep_select_n_o(sleep_select_n_o)
);

//--- dv/tb.sv
// self-checking bench: programs random settings, sleeps, wakes
// assumes the controller and the behavioural memory model
`timescale 1ns/100ps
module tb;
   localparam int RCY = 20;
   logic ref_clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0, rd_data_o, rdv, seed = 32'h824609cd;
   logic [21:0] psram_addr_o, dev_mode, m;
   logic chip_en_n_o, chip_en2_o, write_n_o, sleep_select_n_o, dev_partial, dev_deep;
   logic dev_reduced, oe_n, ub_n, lb_n;
   int miscompares = 0, check_count = 0, cyc = 0, n;
   always #20 ref_clk_i = ~ref_clk_i;
   psram_mode_ctl #(.RECOVER_CYC(RCY)) psram_mode_ctl_inst (.ref_clk_i(ref_clk_i),
      .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .psram_addr_o(psram_addr_o), .chip_en_n_o(chip_en_n_o),
      .chip_en2_o(chip_en2_o), .write_n_o(write_n_o), .out_en_n_o(oe_n),
      .upper_byte_select_n_o(ub_n), .lower_byte_select_n_o(lb_n),
      .sleep_select_n_o(sleep_select_n_o));
   psram_dev_model psram_dev_model_inst (.psram_addr_i(psram_addr_o), .chip_en_n_i(chip_en_n_o),
      .chip_en2_i(chip_en2_o), .write_n_i(write_n_o), .sleep_n_i(sleep_select_n_o),
      .mode_o(dev_mode), .partial_o(dev_partial), .deep_o(dev_deep), .reduced_o(dev_reduced));
   // ==========
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 rdv = rd_data_o;
   endtask
   // n counts the cycles spent busy
   task automatic wait_idle();
      n = 0;
      rd(8'h08);
      while (rdv[0] !== 1'b0 && n < 400) begin
         rd(8'h08);
         n += 2;
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   // ==========
   // main sequence
   initial begin
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      rd(8'h04);
      chk(rdv, 32'h10);
      rd(8'h0c);
      chk(rdv, 32'h0);
      rd(8'h08);
      chk(rdv, 32'h0);
      // last pass drops reduced size after the previous pass set it
      for (int i = 0; i < 5; i++) begin
         seed = xs(seed);
         m = seed[21:0];
         m[4:3] = (i == 4) ? 2'b10 : {i[0], i[1]};
         wr(8'h04, {seed[31:22], m});
         rd(8'h04);
         chk(rdv, {10'h0, m});
         wr(8'h00, 32'h1);
         wait_idle();
         chk({10'h0, dev_mode}, {10'h0, m});
         chk({29'h0, rdv[6:4]}, {29'h0, 1'b1, m[7], m[4] & m[3]});
         chk({29'h0, oe_n, ub_n, lb_n}, {29'h0, 3'b111});
         wr(8'h00, 32'h2);
         repeat (260) @(posedge ref_clk_i);
         rd(8'h08);
         chk({29'h0, rdv[3:1]}, {29'h0, ~m[4], 2'b11});
         chk({30'h0, dev_partial, dev_deep}, {30'h0, m[4], ~m[4]});
         wr(8'h00, 32'h4);
         wait_idle();
         chk({31'h0, n >= RCY}, {31'h0, ~m[4]});
         chk({29'h0, dev_partial, dev_deep, dev_reduced}, {29'h0, 2'b00, m[4] & m[3]});
         $display("test %0d done", i);
      end
      finish_test();
   end
endmodule
